/* File: hw/tlc_tx_launch.sv */
// Transmit launch and collision control registers on a classic Wishbone slave
`timescale 1ns/1ps
`include "tlc_defines.svh"
module tlc_tx_launch #(
	parameter int COLL_LIMIT = `TLC_COLL_LIMIT
)(
	input  wire logic        clk,
	input  wire logic        reset_n,
	input  wire logic        ce,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        pktSent,
	input  wire logic        pktCollision,
	output logic             sendReq,
	output logic             skipPkt,
	output logic             txActive,
	output logic             irq
);
	import tlc_pkg::*;

	// Count width is fixed at seven bits, so the register field must match
	generate
		if (`TLC_COUNT_MSB != 6)
		begin : g_bad_field
			$error("count field must be seven bits");
		end
	endgenerate

	tlc_seq_if sq ();

	// ****************************************
	// Register state
	// ****************************************
	logic [6:0]            pendingCount;
	logic [6:0]            next_pendingCount;
	logic                  launch;
	logic                  next_launch;
	logic                  noHalt;
	logic                  next_noHalt;
	logic                  resumeBit;
	logic                  next_resumeBit;
	logic                  discard;
	logic                  next_discard;
	logic [`TLC_ST_W-1:0]  status;
	logic [`TLC_ST_W-1:0]  next_status;
	logic [`TLC_ST_W-1:0]  irqEn;
	logic [`TLC_ST_W-1:0]  next_irqEn;
	logic [`TLC_ST_W-1:0]  events;
	logic [`TLC_ST_W-1:0]  clearMask;
	logic                  next_irq;
	logic                  next_ack;
	logic [31:0]           next_dat;
	logic                  req;
	logic                  wr;
	logic                  rd;
	logic                  wrLaunch;
	logic                  wrCtl;
	logic                  wrClear;
	logic                  wrEn;

	// ****************************************
	// Bus decode
	// ****************************************
	// Only the low byte lane carries data, so writes need sel bit 0
	assign req      = wb_cyc_i & wb_stb_i & !wb_ack_o;
	assign wr       = req & wb_we_i & wb_sel_i[0];
	assign rd       = req & !wb_we_i;
	// R3: writes are taken whenever offered; the host keeps to idle
	assign wrLaunch = wr && (wb_adr_i == `TLC_ADR_LAUNCH);
	assign wrCtl    = wr && (wb_adr_i == `TLC_ADR_COLLCTL);
	assign wrClear  = wr && (wb_adr_i == `TLC_ADR_CLEAR);
	assign wrEn     = wr && (wb_adr_i == `TLC_ADR_ENABLE);

	// Status events from the sequencer
	assign events[`TLC_ST_DONE] = sq.doneEvt;
	assign events[`TLC_ST_HALT] = sq.haltEvt;
	assign clearMask = wrClear ? wb_dat_i[`TLC_ST_W-1:0] : `TLC_ST_RST;

	// ****************************************
	// Read mux
	// ****************************************
	// Unmapped offsets still answer, with zero, so the master never hangs
	always_comb
	begin
		next_dat = 32'h0000_0000;
		if (rd)
		begin
			unique case (wb_adr_i)
				`TLC_ADR_LAUNCH:
				begin
					// R4: start bit reads one
					next_dat[`TLC_START_BIT] = 1'b1;
					// R7: live packet count
					next_dat[`TLC_COUNT_MSB:0] = pendingCount;
				end
				`TLC_ADR_COLLCTL:
				begin
					next_dat[`TLC_NOHALT_BIT]  = noHalt;
					next_dat[`TLC_RESUME_BIT]  = resumeBit;
					next_dat[`TLC_DISCARD_BIT] = discard;
				end
				`TLC_ADR_STATUS:
					next_dat[`TLC_ST_W-1:0] = status;
				`TLC_ADR_ENABLE:
					next_dat[`TLC_ST_W-1:0] = irqEn;
				`TLC_ADR_STATE:
				begin
					next_dat[0] = sq.active;
					next_dat[1] = (sq.state == TLC_HALT);
				end
				default:
					next_dat = 32'h0000_0000;
			endcase
		end
	end

	// ****************************************
	// Register next values
	// ****************************************
	always_comb
	begin
		next_ack          = req;
		next_pendingCount = pendingCount;
		next_launch       = 1'b0;
		next_noHalt       = noHalt;
		next_resumeBit    = resumeBit;
		next_discard      = discard;
		next_irqEn        = irqEn;
		// R2: count field
		// R5: count and start in one write
		if (wrLaunch)
		begin
			next_pendingCount = wb_dat_i[`TLC_COUNT_MSB:0];
			// R1: start pulse
			next_launch       = wb_dat_i[`TLC_START_BIT];
		end
		// R6: count down per packet
		else if (sq.decCount)
			next_pendingCount = pendingCount - 7'h01;
		// A host write of the resume bit wins over the self clear
		if (wrCtl)
		begin
			next_noHalt    = wb_dat_i[`TLC_NOHALT_BIT];
			next_resumeBit = wb_dat_i[`TLC_RESUME_BIT];
			next_discard   = wb_dat_i[`TLC_DISCARD_BIT];
		end
		// R11: self clear before each packet
		else if (sq.clearResume)
			next_resumeBit = 1'b0;
		if (wrEn)
			next_irqEn = wb_dat_i[`TLC_ST_W-1:0];
		// Set beats clear in the same cycle
		next_status = (status & ~clearMask) | events;
		next_irq    = |(next_status & next_irqEn);
	end

	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			wb_ack_o     <= 1'b0;
			wb_dat_o     <= 32'h0000_0000;
			pendingCount <= `TLC_COUNT_RST;
			launch       <= 1'b0;
			noHalt       <= 1'b0;
			resumeBit    <= 1'b0;
			discard      <= 1'b0;
			status       <= `TLC_ST_RST;
			irqEn        <= `TLC_ST_RST;
			irq          <= 1'b0;
		end
		else if (ce)
		begin
			wb_ack_o     <= next_ack;
			wb_dat_o     <= next_dat;
			pendingCount <= next_pendingCount;
			launch       <= next_launch;
			noHalt       <= next_noHalt;
			resumeBit    <= next_resumeBit;
			discard      <= next_discard;
			status       <= next_status;
			irqEn        <= next_irqEn;
			irq          <= next_irq;
		end
	end

	// ****************************************
	// Sequencer
	// ****************************************
	assign sq.launch    = launch;
	assign sq.count     = pendingCount;
	assign sq.noHalt    = noHalt;
	assign sq.resumeReq = resumeBit;
	assign sq.discard   = discard;

	tlc_tx_sequencer #(
		.COLL_LIMIT   (COLL_LIMIT)
	) u_seq (
		.clk          (clk),
		.reset_n      (reset_n),
		.ce           (ce),
		.pktSent      (pktSent),
		.pktCollision (pktCollision),
		.sq           (sq)
	);

	// Engine-facing outputs are sequencer flops
	assign sendReq  = sq.sendReq;
	assign skipPkt  = sq.skipPkt;
	assign txActive = sq.active;

	// ****************************************
	// Checks
	// ****************************************
	// R4: start bit readback
	chk_start_readback: assert property (@(posedge clk) disable iff (!reset_n) // R4
		ce && rd && wb_adr_i == `TLC_ADR_LAUNCH |=> wb_ack_o && wb_dat_o[`TLC_START_BIT])
		else $error("start bit read as zero");

	// R7: live count readback
	chk_count_readback: assert property (@(posedge clk) disable iff (!reset_n) // R7
		ce && rd && wb_adr_i == `TLC_ADR_LAUNCH
		|=> wb_dat_o[`TLC_COUNT_MSB:0] == $past(pendingCount))
		else $error("count read back wrong");

	// R5: one write loads both
	chk_count_load: assert property (@(posedge clk) disable iff (!reset_n) // R5
		ce && wrLaunch |=> pendingCount == $past(wb_dat_i[6:0]) && launch == $past(wb_dat_i[7]))
		else $error("launch write not taken");

	// R6: count steps down
	chk_count_dec: assert property (@(posedge clk) disable iff (!reset_n) // R6
		ce && sq.decCount && !wrLaunch |=> pendingCount == $past(pendingCount) - 7'h01)
		else $error("count not decremented");

	// R1: prompt start
	chk_launch_start: assert property (@(posedge clk) disable iff (!reset_n) // R1
		ce && wrLaunch && wb_dat_i[7] && wb_dat_i[6:0] != 7'h00 && !sq.active
		|=> ##1 sendReq)
		else $error("launch did not start sending");

	// R11: self clear works
	chk_resume_clear: assert property (@(posedge clk) disable iff (!reset_n) // R11
		sq.clearResume && !wrCtl |=> !resumeBit)
		else $error("resume bit not cleared");

	// R9: resume bit untouched
	chk_resume_masked: assert property (@(posedge clk) disable iff (!reset_n) // R9
		ce && noHalt && !wrCtl |=> resumeBit == $past(resumeBit))
		else $error("resume bit changed in continue mode");

	// R16: idle stays quiet
	chk_idle_quiet: assert property (@(posedge clk) disable iff (!reset_n) // R16
		ce && !sq.active && !launch |=> !sendReq && !sq.active)
		else $error("left idle without start");

	// Empty launch only reports done
	chk_zero_launch: assert property (@(posedge clk) disable iff (!reset_n)
		ce && launch && !sq.active && pendingCount == `TLC_COUNT_RST
		|=> status[`TLC_ST_DONE] && !sq.active)
		else $error("empty launch misbehaved");

	// Sticky done flag
	chk_status_sticky: assert property (@(posedge clk) disable iff (!reset_n)
		sq.doneEvt |=> status[`TLC_ST_DONE])
		else $error("done event lost");

	// Sticky halt flag
	chk_halt_flag: assert property (@(posedge clk) disable iff (!reset_n)
		sq.haltEvt |=> status[`TLC_ST_HALT])
		else $error("halt event lost");

	// Clear without a racing event
	chk_clear_done: assert property (@(posedge clk) disable iff (!reset_n)
		ce && wrClear && wb_dat_i[`TLC_ST_DONE] && !sq.doneEvt |=> !status[`TLC_ST_DONE])
		else $error("done flag not cleared");

	// Level interrupt follows enabled status
	chk_irq_level: assert property (@(posedge clk) disable iff (!reset_n)
		irq == |(status & irqEn))
		else $error("irq out of step with status");

	// Registered answer one cycle on
	chk_ack_follows: assert property (@(posedge clk) disable iff (!reset_n)
		ce && req |=> wb_ack_o)
		else $error("request not acknowledged");

	// Ack is a single pulse
	chk_ack_single: assert property (@(posedge clk) disable iff (!reset_n)
		ce && wb_ack_o |=> !wb_ack_o)
		else $error("ack held two cycles");

	// Read data is zero outside a read
	chk_dat_idle: assert property (@(posedge clk) disable iff (!reset_n)
		ce && !rd |=> wb_dat_o == 32'h0000_0000)
		else $error("read data not zero when idle");
endmodule

/* File: hw/tlc_defines.svh */
// Register map, field positions, reset values and limits of the transmit launch block
// How it works
// R1: Writing one to the launch bit starts sending queued packets at once.
// R2: Launch register bits 6..0 hold the seven-bit pending packet count.
// R3: Host writes the launch register only while idle; reads any time.
// R4: Launch register always reads back a one in the start bit.
// R5: Count and start arrive in one write; new count serves this launch.
// R6: Each completed packet decrements the pending packet count by one.
// R7: Host can read the current pending packet count.
// R8: No-halt select zero halts on sixteenth collision; one never halts.
// R9: No-halt select one masks the resume bit entirely.
// R10: Writing one to the resume bit restarts after a collision halt.
// R11: In halt mode the resume bit clears itself before each packet.
// R12: Discard select picks retry or drop for a packet hitting sixteen collisions.
// R13: Halt mode, resume one, discard zero resends the failed packet.
// R14: Every resume resets the collision counter, allowing sixteen more attempts.
// R15: Skip-resume with nothing queued goes idle and sets transmit done.
// R16: Count reaching zero returns to idle until a new start command.
`ifndef TLC_DEFINES_SVH
`define TLC_DEFINES_SVH

// ****************************************
// Byte offsets on the register bus
// ****************************************
`define TLC_ADR_LAUNCH   8'h00
`define TLC_ADR_COLLCTL  8'h04
`define TLC_ADR_STATUS   8'h08
`define TLC_ADR_CLEAR    8'h0C
`define TLC_ADR_ENABLE   8'h10
`define TLC_ADR_STATE    8'h14

// ****************************************
// Field positions
// ****************************************
`define TLC_START_BIT    7
`define TLC_COUNT_MSB    6
`define TLC_NOHALT_BIT   2
`define TLC_RESUME_BIT   1
`define TLC_DISCARD_BIT  0
`define TLC_ST_DONE      0
`define TLC_ST_HALT      1
`define TLC_ST_W         2

// ****************************************
// Reset values and limits
// ****************************************
`define TLC_COUNT_RST    7'h00
`define TLC_COUNT_ONE    7'h01
`define TLC_CTL_RST      3'h0
`define TLC_ST_RST       2'h0
`define TLC_COLL_LIMIT   16

`endif

/* File: hw/tlc_pkg.sv */
// Types shared by the transmit launch block
package tlc_pkg;
	typedef enum logic [1:0]
	{
		TLC_IDLE = 2'b00,
		TLC_SEND = 2'b01,
		TLC_HALT = 2'b10
	} tlc_state_t;
endpackage

/* File: hw/tlc_seq_if.sv */
// Signals between the register file and the transmit sequencer
`timescale 1ns/1ps
interface tlc_seq_if;
	logic                   launch;
	logic                   resumeReq;
	logic                   noHalt;
	logic                   discard;
	logic [6:0]             count;
	logic                   decCount;
	logic                   clearResume;
	logic                   doneEvt;
	logic                   haltEvt;
	logic                   sendReq;
	logic                   skipPkt;
	logic                   active;
	tlc_pkg::tlc_state_t    state;

	modport regs
	(
		output launch, resumeReq, noHalt, discard, count,
		input  decCount, clearResume, doneEvt, haltEvt, sendReq, skipPkt, active, state
	);
	modport seq
	(
		input  launch, resumeReq, noHalt, discard, count,
		output decCount, clearResume, doneEvt, haltEvt, sendReq, skipPkt, active, state
	);
endinterface

/* File: hw/tlc_tx_sequencer.sv */
// Packet sequencer with collision counting, halt and resume
`timescale 1ns/1ps
`include "tlc_defines.svh"
module tlc_tx_sequencer #(
	parameter int COLL_LIMIT = `TLC_COLL_LIMIT
)(
	input  wire logic clk,
	input  wire logic reset_n,
	input  wire logic ce,
	input  wire logic pktSent,
	input  wire logic pktCollision,
	tlc_seq_if.seq    sq
);
	import tlc_pkg::*;

	localparam int CW = $clog2(COLL_LIMIT);

	// Counter must hold at least two attempts
	generate
		if (COLL_LIMIT < 2 || COLL_LIMIT > 256)
		begin : g_bad_limit
			$error("COLL_LIMIT out of range");
		end
	endgenerate

	tlc_state_t       state;
	tlc_state_t       next_state;
	logic [CW-1:0]    collCnt;
	logic [CW-1:0]    next_collCnt;
	logic             sendReq;
	logic             skipPkt;
	logic             active;
	logic             next_skip;
	logic             dec;
	logic             clr;
	logic             done;
	logic             halt;
	logic             lastPkt;
	logic             atLimit;

	assign lastPkt = (sq.count == `TLC_COUNT_ONE);
	assign atLimit = (collCnt == CW'(COLL_LIMIT - 1));

	// ****************************************
	// Next state
	// ****************************************
	// Decrement and event strobes are combinational so the count moves on the same edge
	always_comb
	begin
		next_state   = state;
		next_collCnt = collCnt;
		next_skip    = 1'b0;
		dec          = 1'b0;
		clr          = 1'b0;
		done         = 1'b0;
		halt         = 1'b0;
		unique case (state)
			TLC_IDLE:
			begin
				// R1: start on launch
				if (sq.launch)
				begin
					if (sq.count != `TLC_COUNT_RST)
					begin
						next_state   = TLC_SEND;
						next_collCnt = '0;
						clr          = !sq.noHalt;
					end
					else
						done = 1'b1;
				end
			end
			TLC_SEND:
			begin
				// R6: completed packet counts down
				if (pktSent)
				begin
					dec          = 1'b1;
					next_collCnt = '0;
					// R16: last packet ends run
					if (lastPkt)
					begin
						next_state = TLC_IDLE;
						done       = 1'b1;
					end
					else
						// R11: auto clear resume
						clr = !sq.noHalt;
				end
				else if (pktCollision)
				begin
					if (atLimit)
					begin
						next_collCnt = '0;
						// R8: halt or continue
						if (!sq.noHalt)
						begin
							next_state = TLC_HALT;
							halt       = 1'b1;
						end
						// R12: drop failed packet
						else if (sq.discard)
						begin
							next_skip = 1'b1;
							dec       = 1'b1;
							if (lastPkt)
							begin
								next_state = TLC_IDLE;
								done       = 1'b1;
							end
						end
					end
					else
						next_collCnt = collCnt + CW'(1);
				end
			end
			TLC_HALT:
			begin
				// R9: resume masked in auto mode, which simply carries on
				// R10: resume after halt
				if (sq.noHalt || sq.resumeReq)
				begin
					// R14: fresh attempt budget
					next_collCnt = '0;
					if (sq.discard)
					begin
						next_skip = 1'b1;
						dec       = 1'b1;
					end
					// R15: skip with nothing left
					if (sq.discard && lastPkt)
					begin
						next_state = TLC_IDLE;
						done       = 1'b1;
					end
					else
					begin
						// R13: resend failed packet
						next_state = TLC_SEND;
						clr        = !sq.noHalt;
					end
				end
			end
			default:
				next_state = TLC_IDLE;
		endcase
	end

	// ****************************************
	// State registers
	// ****************************************
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			state   <= TLC_IDLE;
			collCnt <= '0;
			sendReq <= 1'b0;
			skipPkt <= 1'b0;
			active  <= 1'b0;
		end
		else if (ce)
		begin
			state   <= next_state;
			collCnt <= next_collCnt;
			sendReq <= (next_state == TLC_SEND);
			skipPkt <= next_skip;
			active  <= (next_state != TLC_IDLE);
		end
	end

	// Strobes gated by the clock enable so a frozen cycle fires none of them
	assign sq.decCount    = dec & ce;
	assign sq.clearResume = clr & ce;
	assign sq.doneEvt     = done & ce;
	assign sq.haltEvt     = halt & ce;
	assign sq.sendReq     = sendReq;
	assign sq.skipPkt     = skipPkt;
	assign sq.active      = active;
	assign sq.state       = state;

	// ****************************************
	// Checks
	// ****************************************
	// R8: halt at limit
	chk_halt_on_limit: assert property (@(posedge clk) disable iff (!reset_n) // R8
		ce && state == TLC_SEND && !pktSent && pktCollision && atLimit && !sq.noHalt
		|=> state == TLC_HALT && !sendReq)
		else $error("no halt on collision limit");
	// R8: continue never halts
	chk_never_halt: assert property (@(posedge clk) disable iff (!reset_n) // R8
		ce && state == TLC_SEND && sq.noHalt |=> state != TLC_HALT)
		else $error("halted in continue mode");
	// R10: halt needs resume
	chk_halt_holds: assert property (@(posedge clk) disable iff (!reset_n) // R10
		state == TLC_HALT && !sq.noHalt && !sq.resumeReq |=> state == TLC_HALT)
		else $error("left halt without resume");
	// R13: resume resends packet
	chk_resume_retry: assert property (@(posedge clk) disable iff (!reset_n) // R13
		ce && state == TLC_HALT && sq.resumeReq && !sq.noHalt && !sq.discard
		|=> state == TLC_SEND && collCnt == '0 && !skipPkt)
		else $error("resume did not resend");
	// R15: skip empties queue
	chk_skip_empty: assert property (@(posedge clk) disable iff (!reset_n) // R15
		ce && state == TLC_HALT && sq.resumeReq && sq.discard && lastPkt
		|-> sq.doneEvt ##1 state == TLC_IDLE && skipPkt)
		else $error("skip with empty queue not idle");
	// R16: idle at zero
	chk_idle_at_zero: assert property (@(posedge clk) disable iff (!reset_n) // R16
		ce && state == TLC_SEND && pktSent && lastPkt
		|=> state == TLC_IDLE && !active && !sendReq)
		else $error("not idle after last packet");
endmodule

/* File: test/tlc_engine_model.sv */
// Behavioural transmit engine that answers the sequencer's send requests
`timescale 1ns/1ps
module tlc_engine_model
(
	input  wire logic       clk,
	input  wire logic       reset_n,
	input  wire logic       sendReq,
	input  wire logic       skipPkt,
	input  wire logic       collide,
	input  wire logic [3:0] gap,
	output logic            pktSent,
	output logic            pktCollision
);
	logic [3:0] cnt;

	// ****************************************
	// Attempt timing
	// ****************************************
	// One attempt every gap+2 cycles; restarting after a pulse keeps pulses apart
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			cnt          <= 4'h0;
			pktSent      <= 1'b0;
			pktCollision <= 1'b0;
		end
		else if (!sendReq || skipPkt || pktSent || pktCollision)
		begin
			cnt          <= 4'h0;
			pktSent      <= 1'b0;
			pktCollision <= 1'b0;
		end
		else if (cnt == gap)
		begin
			cnt          <= 4'h0;
			pktSent      <= !collide; // A good send or a collided attempt
			pktCollision <= collide;
		end
		else
		begin
			cnt <= cnt + 4'h1;
		end
	end
endmodule

/* File: test/tb.sv */
// Self-checking bench of the transmit launch and collision control block
`timescale 1ns/1ps
`include "tlc_defines.svh"
`define CHK(got, exp, msg) \
	begin \
		checked++; \
		if ((got) !== (exp)) \
		begin \
			err_total++; \
			$display("MISMATCH %0t %s", $time, msg); \
		end \
	end
module tb;
	logic        clk, reset_n, ce, cyc, stb, we, ack;
	logic [7:0]  adr;
	logic [3:0]  sel, gap;
	logic [31:0] dw, dr;
	logic        pktSent, pktCollision, sendReq, skipPkt, txActive, irq, collide;
	int          err_total, checked, cycles, nColl, nSent, nSkip, c0, n0, s0;

	tlc_tx_launch dut (.clk(clk), .reset_n(reset_n), .ce(ce), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dw),
		.wb_dat_o(dr), .wb_ack_o(ack), .pktSent(pktSent), .pktCollision(pktCollision),
		.sendReq(sendReq), .skipPkt(skipPkt), .txActive(txActive), .irq(irq));
	tlc_engine_model eng (.clk(clk), .reset_n(reset_n), .sendReq(sendReq),
		.skipPkt(skipPkt), .collide(collide), .gap(gap), .pktSent(pktSent),
		.pktCollision(pktCollision));

	// ****************************************
	// Clock, event counters and hang guard
	// ****************************************
	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// Ceiling well above the thousand or so cycles the tests need
	always @(posedge clk)
	begin
		cycles++;
		nColl += (pktCollision === 1'b1);
		nSent += (pktSent === 1'b1);
		nSkip += (skipPkt === 1'b1);
		if (cycles == 60000)
		begin
			err_total++;
			end_sim();
		end
	end

	// ****************************************
	// Bus tasks
	// ****************************************
	// Classic cycle held until ack; the next one starts an edge later
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we  <= 1'b1;
		adr <= a;
		dw  <= v;
		sel <= 4'hF;
		do @(posedge clk); while (ack !== 1'b1);
		cyc <= 1'b0;
		stb <= 1'b0;
		we  <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we  <= 1'b0;
		adr <= a;
		do @(posedge clk); while (ack !== 1'b1);
		v = dr;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task automatic chk_rd(input logic [7:0] a, input logic [31:0] e, input string m);
		logic [31:0] v;
		rd(a, v);
		`CHK(v, e, m)
	endtask
	// Bounded only by the hang guard
	task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		logic [31:0] v;
		do rd(a, v); while ((v & m) !== e);
	endtask
	task automatic settle;
		@(posedge clk);
		#1;
	endtask
	task automatic end_sim;
		$display("checked %0d err_total %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// ****************************************
	// Tests
	// ****************************************
	initial
	begin
		{cyc, stb, we, adr, sel, dw} = '0;
		ce      = 1'b1;
		collide = 1'b0;
		gap     = 4'h9;
		reset_n = 1'b0;
		repeat (20) @(posedge clk);
		reset_n <= 1'b1;
		chk_rd(`TLC_ADR_LAUNCH, 32'h0000_0080, "launch reset");
		chk_rd(`TLC_ADR_COLLCTL, 32'h0000_0000, "ctl reset");
		chk_rd(`TLC_ADR_STATUS, 32'h0000_0000, "status reset");
		chk_rd(8'h18, 32'h0000_0000, "unmapped read");
		wr(`TLC_ADR_ENABLE, 32'h0000_0003);
		chk_rd(`TLC_ADR_ENABLE, 32'h0000_0003, "enable rw");
		$display("test reset done");
		// Plain launch of three good packets, written while idle
		n0 = nSent;
		wr(`TLC_ADR_LAUNCH, 32'h0000_0083);
		settle();
		`CHK(sendReq, 1'b1, "send not started")
		chk_rd(`TLC_ADR_LAUNCH, 32'h0000_0083, "count live");
		poll(`TLC_ADR_STATE, 32'h0000_0001, 32'h0000_0000);
		`CHK(nSent - n0, 3, "sent count")
		chk_rd(`TLC_ADR_LAUNCH, 32'h0000_0080, "count end");
		chk_rd(`TLC_ADR_STATUS, 32'h0000_0001, "done flag");
		`CHK(irq, 1'b1, "irq enabled")
		repeat (30) @(posedge clk);
		`CHK(nSent - n0, 3, "sent after idle")
		wr(`TLC_ADR_ENABLE, 32'h0000_0000);
		settle();
		`CHK(irq, 1'b0, "irq masked")
		wr(`TLC_ADR_ENABLE, 32'h0000_0003);
		settle();
		`CHK(irq, 1'b1, "irq unmasked")
		wr(`TLC_ADR_CLEAR, 32'h0000_0001);
		chk_rd(`TLC_ADR_STATUS, 32'h0000_0000, "status cleared");
		`CHK(irq, 1'b0, "irq cleared")
		$display("test launch done");
		// Halt on collisions, repeat, then skip
		gap     <= 4'h3;
		collide <= 1'b1;
		c0 = nColl;
		wr(`TLC_ADR_COLLCTL, 32'h0000_0000);
		wr(`TLC_ADR_LAUNCH, 32'h0000_0082);
		poll(`TLC_ADR_STATUS, 32'h0000_0002, 32'h0000_0002);
		`CHK(nColl - c0, `TLC_COLL_LIMIT, "halt point")
		`CHK(sendReq, 1'b0, "send in halt")
		chk_rd(`TLC_ADR_STATE, 32'h0000_0003, "halt state");
		wr(`TLC_ADR_CLEAR, 32'h0000_0002);
		wr(`TLC_ADR_COLLCTL, 32'h0000_0002);
		poll(`TLC_ADR_STATUS, 32'h0000_0002, 32'h0000_0002);
		`CHK(nColl - c0, 2 * `TLC_COLL_LIMIT, "second halt")
		chk_rd(`TLC_ADR_COLLCTL, 32'h0000_0000, "resume cleared");
		chk_rd(`TLC_ADR_LAUNCH, 32'h0000_0082, "same packet");
		collide <= 1'b0;
		n0 = nSent;
		s0 = nSkip;
		wr(`TLC_ADR_CLEAR, 32'h0000_0003);
		wr(`TLC_ADR_COLLCTL, 32'h0000_0003);
		poll(`TLC_ADR_STATE, 32'h0000_0001, 32'h0000_0000);
		`CHK(nSent - n0, 1, "next after skip")
		`CHK(nSkip - s0, 1, "one skip")
		chk_rd(`TLC_ADR_LAUNCH, 32'h0000_0080, "count after skip");
		// Skip with nothing behind the failed packet
		collide <= 1'b1;
		wr(`TLC_ADR_CLEAR, 32'h0000_0003);
		wr(`TLC_ADR_LAUNCH, 32'h0000_0081);
		poll(`TLC_ADR_STATUS, 32'h0000_0002, 32'h0000_0002);
		wr(`TLC_ADR_CLEAR, 32'h0000_0003);
		wr(`TLC_ADR_COLLCTL, 32'h0000_0003);
		poll(`TLC_ADR_STATE, 32'h0000_0001, 32'h0000_0000);
		chk_rd(`TLC_ADR_STATUS, 32'h0000_0001, "done on last skip");
		chk_rd(`TLC_ADR_LAUNCH, 32'h0000_0080, "count on last skip");
		$display("test halt done");
		// Automatic continue, dropping each failed packet
		c0 = nColl;
		wr(`TLC_ADR_CLEAR, 32'h0000_0003);
		wr(`TLC_ADR_COLLCTL, 32'h0000_0007);
		wr(`TLC_ADR_LAUNCH, 32'h0000_0082);
		poll(`TLC_ADR_STATE, 32'h0000_0001, 32'h0000_0000);
		`CHK(nColl - c0, 2 * `TLC_COLL_LIMIT, "auto drop")
		chk_rd(`TLC_ADR_STATUS, 32'h0000_0001, "no halt flag");
		// Automatic continue, repeating; the resume bit must change nothing
		c0 = nColl;
		n0 = nSent;
		wr(`TLC_ADR_CLEAR, 32'h0000_0003);
		wr(`TLC_ADR_COLLCTL, 32'h0000_0006);
		wr(`TLC_ADR_LAUNCH, 32'h0000_0081);
		repeat (200) @(posedge clk);
		`CHK(txActive, 1'b1, "still sending")
		`CHK((nColl - c0) > 2 * `TLC_COLL_LIMIT, 1'b1, "retries go on")
		chk_rd(`TLC_ADR_STATUS, 32'h0000_0000, "auto no halt");
		chk_rd(`TLC_ADR_COLLCTL, 32'h0000_0006, "resume kept");
		collide <= 1'b0;
		poll(`TLC_ADR_STATE, 32'h0000_0001, 32'h0000_0000);
		`CHK(nSent - n0, 1, "repeat succeeds")
		chk_rd(`TLC_ADR_LAUNCH, 32'h0000_0080, "auto count");
		$display("test auto done");
		// Empty launch only reports done
		wr(`TLC_ADR_CLEAR, 32'h0000_0003);
		wr(`TLC_ADR_LAUNCH, 32'h0000_0080);
		chk_rd(`TLC_ADR_STATUS, 32'h0000_0001, "empty launch done");
		`CHK(txActive, 1'b0, "empty launch idle")
		// Frozen enable must hide collisions that would otherwise halt
		collide <= 1'b1;
		wr(`TLC_ADR_COLLCTL, 32'h0000_0000);
		wr(`TLC_ADR_CLEAR, 32'h0000_0003);
		wr(`TLC_ADR_LAUNCH, 32'h0000_0081);
		ce <= 1'b0;
		repeat (200) @(posedge clk);
		`CHK(sendReq, 1'b1, "frozen no halt")
		ce      <= 1'b1;
		collide <= 1'b0;
		poll(`TLC_ADR_STATE, 32'h0000_0001, 32'h0000_0000);
		chk_rd(`TLC_ADR_STATUS, 32'h0000_0001, "frozen done");
		chk_rd(`TLC_ADR_LAUNCH, 32'h0000_0080, "frozen count");
		$display("test enable done");
		end_sim();
	end
endmodule
